// File: inc/prm_pkg.sv
package prm_pkg;

	// Register addresses (byte wide nibble space)
	localparam logic [7:0] ADDR_PA_LOW_DATA   = 8'h50;
	localparam logic [7:0] ADDR_PA_LOW_OE     = 8'h51;
	localparam logic [7:0] ADDR_PA_EDGE_DEB   = 8'h52;
	localparam logic [7:0] ADDR_PA_WAKE_IRQ   = 8'h53;
	localparam logic [7:0] ADDR_PA_PD_DIS     = 8'h54;
	localparam logic [7:0] ADDR_PA_OD_SEL     = 8'h55;
	localparam logic [7:0] ADDR_FREQ_RST      = 8'h56;
	localparam logic [7:0] ADDR_SER_CTL1      = 8'h57;
	localparam logic [7:0] ADDR_SER_CTL2      = 8'h58;
	localparam logic [7:0] ADDR_SER_DATA_L    = 8'h59;
	localparam logic [7:0] ADDR_SER_DATA_H    = 8'h5a;
	localparam logic [7:0] ADDR_CNT_CTL1      = 8'h5b;
	localparam logic [7:0] ADDR_CNT_CTL2      = 8'h5c;
	localparam logic [7:0] ADDR_CNT_DATA_L    = 8'h5d;
	localparam logic [7:0] ADDR_CNT_DATA_M    = 8'h5e;
	localparam logic [7:0] ADDR_CNT_DATA_H    = 8'h5f;
	localparam logic [7:0] ADDR_PA_HIGH_DATA  = 8'h60;
	localparam logic [7:0] ADDR_PA_ROUTE1     = 8'h61;
	localparam logic [7:0] ADDR_PA_ROUTE2     = 8'h62;
	localparam logic [7:0] ADDR_IRQ_MASK1     = 8'h65;
	localparam logic [7:0] ADDR_IRQ_MASK2     = 8'h66;
	localparam logic [7:0] ADDR_IRQ_FLAG1     = 8'h67;
	localparam logic [7:0] ADDR_IRQ_FLAG2     = 8'h68;
	localparam logic [7:0] ADDR_SYS_CTL1      = 8'h69;
	localparam logic [7:0] ADDR_SYS_CTL2      = 8'h6a;
	localparam logic [7:0] ADDR_SLEEP_CR      = 8'h6b;

	// Reset values
	localparam logic [3:0] RST_ZERO           = 4'h0;
	localparam logic [3:0] RST_SYS_CTL2_SLEEP = 4'h0;

	// Field positions
	localparam int PA5_IN_BIT       = 1;
	localparam int PA5_OE_BIT       = 2;
	localparam int PA5_OD_BIT       = 3;
	localparam int CNT_LOAD_BIT     = 0;
	localparam int SYS1_SLEEP_BIT   = 2;
	localparam int SYS2_SLEEP_EN    = 2;
	localparam int SYS2_POR_BIT     = 3;
	localparam int SYS2_WD_RESTART  = 3;
	localparam int SER2_STATUS_BIT  = 2;

endpackage : prm_pkg

// File: src/prm_regs.sv
`timescale 1ns/1ps
// Functional notes
// - All registers reset to documented values
// - Port low read pins, write output data
// - Port low output enable active high
// - Port high: pin levels, pin5 enable, drain
// - Edge select and debounce bypass per pair
// - Interrupt source and wake-on-change enables
// - Set bit turns pull-down off
// - Set bit selects open-drain output
// - Frequency select, reset input enable, polarity
// - Serial order, edge, two-bit mode
// - Serial mode, oscillator stop, status, start
// - Counter control two; load strobe reads zero
// - Counter clock select and direction
// - Zero mask bit blocks flag storage
// - Writing one clears a flag
// - System control one; sleep strobe reads zero
// - Watchdog value, sleep enable, power-on flag
// - Sleep period, counter off, pin4 pull
// - Routing of PWM and serial onto pins
// - Flag register read clears only that register's four flags
// - Flags set on masked rising request edge
module prm_regs
	import prm_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [7:0] address,
	input  wire logic [3:0] write_data,
	input  wire logic       write_strobe,
	input  wire logic       read_strobe,
	output logic      [3:0] read_data,
	input  wire logic [5:0] port_pin_in,
	input  wire logic [7:0] irq_request,
	input  wire logic [1:0] watchdog_value,
	input  wire logic       serial_busy,
	input  wire logic [9:0] counter_value,
	output logic      [5:0] port_out_value,
	output logic      [5:0] port_drive_enable,
	output logic      [5:0] open_drain_sel,
	output logic      [3:0] pulldown_off,
	output logic      [3:0] edge_debounce_ctl,
	output logic      [3:0] wake_irq_ctl,
	output logic      [3:0] freq_reset_ctl,
	output logic      [3:0] serial_ctl_one,
	output logic      [3:0] serial_ctl_two,
	output logic      [7:0] serial_data,
	output logic      [3:0] counter_ctl_one,
	output logic      [2:0] counter_ctl_two,
	output logic            counter_load,
	output logic      [9:0] reload_value,
	output logic      [1:0] width_select,
	output logic      [3:0] route_one,
	output logic      [3:0] route_two,
	output logic      [7:0] irq_flags,
	output logic      [3:0] system_ctl_one,
	output logic            sleep_request,
	output logic            sleep_allow,
	output logic            watchdog_restart,
	output logic      [3:0] sleep_counter_ctl
);

	typedef struct packed {
		logic [3:0] rdata;
		logic [5:0] pin_s1;
		logic [5:0] pin_s2;
		logic [7:0] req_s1;
		logic [7:0] req_s2;
		logic [7:0] req_old;
		logic [5:0] pout;
		logic [5:0] oe;
		logic [5:0] od;
		logic [3:0] pd_off;
		logic [3:0] edge_deb;
		logic [3:0] wake_irq;
		logic [3:0] freq_rst;
		logic [3:0] ser1;
		logic [3:0] ser2;
		logic [7:0] sdata;
		logic [3:0] cnt1;
		logic [2:0] cnt2;
		logic       load;
		logic [9:0] reload;
		logic [1:0] wsel;
		logic [3:0] route1;
		logic [3:0] route2;
		logic [7:0] mask;
		logic [7:0] flags;
		logic [3:0] sys1;
		logic       sleep_req;
		logic       sleep_en;
		logic       por_flag;
		logic       wd_restart;
		logic [3:0] sleep_cr;
		logic       clr1_pend;
		logic       clr2_pend;
	} prm_state_type;

	prm_state_type state_reg;
	prm_state_type state_next;
	logic [7:0]    req_rise;
	logic [7:0]    clr_mask;

	always_comb begin
		state_next = state_reg;
		// Pins and requests come from other domains
		state_next.pin_s1 = port_pin_in;
		state_next.pin_s2 = state_reg.pin_s1;
		state_next.req_s1 = irq_request;
		state_next.req_s2 = state_reg.req_s1;
		state_next.req_old = state_reg.req_s2;
		state_next.load = 1'b0;
		state_next.sleep_req = 1'b0;
		state_next.wd_restart = 1'b0;
		state_next.clr1_pend = 1'b0;
		state_next.clr2_pend = 1'b0;
		state_next.rdata = 4'h0;
		req_rise = state_reg.req_s2 & ~state_reg.req_old & state_reg.mask;
		// Clear from last cycle's read or from a write of ones
		clr_mask = {{4{state_reg.clr2_pend}}, {4{state_reg.clr1_pend}}};
		if (write_strobe && address == ADDR_IRQ_FLAG1)
			clr_mask[3:0] = clr_mask[3:0] | write_data;
		if (write_strobe && address == ADDR_IRQ_FLAG2)
			clr_mask[7:4] = clr_mask[7:4] | write_data;
		// New event beats a same-cycle clear
		state_next.flags = (state_reg.flags & ~clr_mask) | req_rise;

		if (write_strobe) begin
			unique case (address)
				ADDR_PA_LOW_DATA:  state_next.pout[3:0] = write_data;
				ADDR_PA_LOW_OE:    state_next.oe[3:0] = write_data;
				ADDR_PA_EDGE_DEB:  state_next.edge_deb = write_data;
				ADDR_PA_WAKE_IRQ:  state_next.wake_irq = write_data;
				ADDR_PA_PD_DIS:    state_next.pd_off = write_data;
				ADDR_PA_OD_SEL:    state_next.od[3:0] = write_data;
				ADDR_FREQ_RST:     state_next.freq_rst = write_data;
				ADDR_SER_CTL1:     state_next.ser1 = write_data;
				ADDR_SER_CTL2:     state_next.ser2 = write_data;
				ADDR_SER_DATA_L:   state_next.sdata[3:0] = write_data;
				ADDR_SER_DATA_H:   state_next.sdata[7:4] = write_data;
				ADDR_CNT_CTL1:     state_next.cnt1 = write_data;
				ADDR_CNT_CTL2: begin
					state_next.cnt2 = write_data[3:1];
					state_next.load = write_data[CNT_LOAD_BIT];
				end
				ADDR_CNT_DATA_L:   state_next.reload[3:0] = write_data;
				ADDR_CNT_DATA_M:   state_next.reload[7:4] = write_data;
				ADDR_CNT_DATA_H: begin
					state_next.reload[9:8] = write_data[1:0];
					state_next.wsel = write_data[3:2];
				end
				ADDR_PA_HIGH_DATA: begin
					state_next.pout[5] = write_data[PA5_IN_BIT];
					state_next.oe[5] = write_data[PA5_OE_BIT];
					state_next.od[5] = write_data[PA5_OD_BIT];
				end
				ADDR_PA_ROUTE1:    state_next.route1 = write_data;
				ADDR_PA_ROUTE2:    state_next.route2 = write_data;
				ADDR_IRQ_MASK1:    state_next.mask[3:0] = write_data;
				ADDR_IRQ_MASK2:    state_next.mask[7:4] = write_data;
				ADDR_SYS_CTL1: begin
					state_next.sys1 = write_data & 4'hb;
					state_next.sleep_req = write_data[SYS1_SLEEP_BIT];
				end
				ADDR_SYS_CTL2: begin
					state_next.sleep_en = write_data[SYS2_SLEEP_EN];
					state_next.wd_restart = write_data[SYS2_WD_RESTART];
				end
				ADDR_SLEEP_CR:     state_next.sleep_cr = write_data;
				default:           state_next.pout = state_reg.pout;
			endcase
		end

		if (read_strobe) begin
			unique case (address)
				ADDR_PA_LOW_DATA:  state_next.rdata = state_reg.pin_s2[3:0];
				ADDR_PA_LOW_OE:    state_next.rdata = state_reg.oe[3:0];
				ADDR_PA_EDGE_DEB:  state_next.rdata = state_reg.edge_deb;
				ADDR_PA_WAKE_IRQ:  state_next.rdata = state_reg.wake_irq;
				ADDR_PA_PD_DIS:    state_next.rdata = state_reg.pd_off;
				ADDR_PA_OD_SEL:    state_next.rdata = state_reg.od[3:0];
				ADDR_FREQ_RST:     state_next.rdata = state_reg.freq_rst;
				ADDR_SER_CTL1:     state_next.rdata = state_reg.ser1;
				ADDR_SER_CTL2: begin
					state_next.rdata = state_reg.ser2;
					state_next.rdata[SER2_STATUS_BIT] = serial_busy;
				end
				ADDR_SER_DATA_L:   state_next.rdata = state_reg.sdata[3:0];
				ADDR_SER_DATA_H:   state_next.rdata = state_reg.sdata[7:4];
				ADDR_CNT_CTL1:     state_next.rdata = state_reg.cnt1;
				ADDR_CNT_CTL2:     state_next.rdata = {state_reg.cnt2, 1'b0};
				ADDR_CNT_DATA_L:   state_next.rdata = counter_value[3:0];
				ADDR_CNT_DATA_M:   state_next.rdata = counter_value[7:4];
				ADDR_CNT_DATA_H:   state_next.rdata = {state_reg.wsel, counter_value[9:8]};
				ADDR_PA_HIGH_DATA: state_next.rdata = {state_reg.od[5], state_reg.oe[5],
					state_reg.pin_s2[5:4]};
				ADDR_PA_ROUTE1:    state_next.rdata = state_reg.route1;
				ADDR_PA_ROUTE2:    state_next.rdata = state_reg.route2;
				ADDR_IRQ_MASK1:    state_next.rdata = state_reg.mask[3:0];
				ADDR_IRQ_MASK2:    state_next.rdata = state_reg.mask[7:4];
				ADDR_IRQ_FLAG1: begin
					state_next.rdata = state_reg.flags[3:0];
					state_next.clr1_pend = 1'b1;
				end
				ADDR_IRQ_FLAG2: begin
					state_next.rdata = state_reg.flags[7:4];
					state_next.clr2_pend = 1'b1;
				end
				ADDR_SYS_CTL1:     state_next.rdata = state_reg.sys1;
				ADDR_SYS_CTL2:     state_next.rdata = {state_reg.por_flag, state_reg.sleep_en,
					watchdog_value};
				ADDR_SLEEP_CR:     state_next.rdata = state_reg.sleep_cr;
				default:           state_next.rdata = 4'h0;
			endcase
		end
	end

	// Only flags of the register read are cleared, on the edge after the read; a flag set on the read edge itself is cleared unread
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.sleep_en <= RST_SYS_CTL2_SLEEP[0];
			state_reg.por_flag <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign read_data         = state_reg.rdata;
	assign port_out_value    = state_reg.pout;
	assign port_drive_enable = state_reg.oe;
	assign open_drain_sel    = state_reg.od;
	assign pulldown_off      = state_reg.pd_off;
	assign edge_debounce_ctl = state_reg.edge_deb;
	assign wake_irq_ctl      = state_reg.wake_irq;
	assign freq_reset_ctl    = state_reg.freq_rst;
	assign serial_ctl_one    = state_reg.ser1;
	assign serial_ctl_two    = state_reg.ser2;
	assign serial_data       = state_reg.sdata;
	assign counter_ctl_one   = state_reg.cnt1;
	assign counter_ctl_two   = state_reg.cnt2;
	assign counter_load      = state_reg.load;
	assign reload_value      = state_reg.reload;
	assign width_select      = state_reg.wsel;
	assign route_one         = state_reg.route1;
	assign route_two         = state_reg.route2;
	assign irq_flags         = state_reg.flags;
	assign system_ctl_one    = state_reg.sys1;
	assign sleep_request     = state_reg.sleep_req;
	assign sleep_allow       = state_reg.sleep_en;
	assign watchdog_restart  = state_reg.wd_restart;
	assign sleep_counter_ctl = state_reg.sleep_cr;

endmodule : prm_regs

// File: dv/prm_regs_props.sv
`timescale 1ns/1ps
module prm_regs_props (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic [7:0] address,
	input wire logic [3:0] write_data,
	input wire logic       write_strobe,
	input wire logic       read_strobe,
	input wire logic [3:0] read_data,
	input wire logic [7:0] irq_request,
	input wire logic [7:0] irq_flags,
	input wire logic [5:0] port_drive_enable,
	input wire logic       counter_load,
	input wire logic       sleep_request,
	input wire logic       watchdog_restart,
	input wire logic [3:0] system_ctl_one
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_oe_write: assert property (write_strobe && address == 8'h51 |=>
		port_drive_enable[3:0] == $past(write_data)) else $error("drive enable not written");
	a_load_pulse: assert property (counter_load ==
		$past(write_strobe && address == 8'h5c && write_data[0])) else $error("load pulse wrong");
	a_load_reads_zero: assert property (read_strobe && address == 8'h5c |=> !read_data[0])
		else $error("load bit read back");
	a_sleep_pulse: assert property (sleep_request ==
		$past(write_strobe && address == 8'h69 && write_data[2])) else $error("sleep pulse wrong");
	a_sleep_bit_low: assert property (!system_ctl_one[2]) else $error("sleep bit stored");
	a_wd_restart: assert property (watchdog_restart ==
		$past(write_strobe && address == 8'h6a && write_data[3])) else $error("restart pulse wrong");
	a_unmapped_zero: assert property (read_strobe && (address == 8'h63 || address == 8'h64)
		|=> read_data == 4'h0) else $error("unmapped read not zero");
	// Quiet requests only, so a late edge cannot refill a flag
	a_flag_rd_clear: assert property (read_strobe && address == 8'h67 && irq_request[3:0] == 4'h0
		&& $past(irq_request[3:0]) == 4'h0 |=> ##1 irq_flags[3:0] == 4'h0) else $error("flags not cleared");
	a_flag_on_edge: assert property ($rose(irq_flags[0]) |->
		$past(irq_request[0], 3) && !$past(irq_request[0], 4)) else $error("flag without edge");
endmodule : prm_regs_props

bind prm_regs prm_regs_props prm_regs_props_i (.clock, .reset_n, .address, .write_data, .write_strobe,
	.read_strobe, .read_data, .irq_request, .irq_flags, .port_drive_enable, .counter_load, .sleep_request,
	.watchdog_restart, .system_ctl_one);

// File: dv/prm_cpu_model.sv
`timescale 1ns/1ps
// One nibble access per call; the core never overlaps two
module prm_cpu_model (
	input  wire logic       clock,
	input  wire logic [3:0] read_data,
	output logic      [7:0] address,
	output logic      [3:0] write_data,
	output logic            write_strobe,
	output logic            read_strobe
);
	initial begin
		address = 8'h00;
		write_data = 4'h0;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
	end
	task automatic write(input logic [7:0] a, input logic [3:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
		// Hand back one edge later so the written value has settled
		@(posedge clock);
	endtask : write
	task automatic read(input logic [7:0] a, output logic [3:0] d);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		// Data stand in this cycle only; take them at its closing edge
		@(posedge clock);
		d = read_data;
	endtask : read
endmodule : prm_cpu_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import prm_pkg::*;
	logic clock, reset_n, write_strobe, read_strobe, serial_busy;
	logic [7:0] address, irq_request, irq_flags, serial_data;
	logic [3:0] write_data, read_data, pulldown_off, edge_debounce_ctl, wake_irq_ctl, freq_reset_ctl;
	logic [3:0] serial_ctl_one, serial_ctl_two, counter_ctl_one, route_one, route_two, system_ctl_one;
	logic [3:0] sleep_counter_ctl;
	logic [5:0] port_pin_in, port_out_value, port_drive_enable, open_drain_sel;
	logic [9:0] counter_value, reload_value;
	logic [2:0] counter_ctl_two;
	logic [1:0] watchdog_value, width_select;
	logic counter_load, sleep_request, sleep_allow, watchdog_restart;
	int fails = 0;
	int checks = 0;
	logic [7:0] zero_regs[15] = '{8'h50, 8'h51, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e,
		8'h5f, 8'h65, 8'h66, 8'h67, 8'h68};
	logic [7:0] rw_regs[15] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h59, 8'h5a, 8'h5b,
		8'h61, 8'h62, 8'h65, 8'h66, 8'h6b};

	prm_regs prm_regs_i (.clock, .reset_n, .address, .write_data, .write_strobe, .read_strobe, .read_data,
		.port_pin_in, .irq_request, .watchdog_value, .serial_busy, .counter_value, .port_out_value,
		.port_drive_enable, .open_drain_sel, .pulldown_off, .edge_debounce_ctl, .wake_irq_ctl,
		.freq_reset_ctl, .serial_ctl_one, .serial_ctl_two, .serial_data, .counter_ctl_one, .counter_ctl_two,
		.counter_load, .reload_value, .width_select, .route_one, .route_two, .irq_flags, .system_ctl_one,
		.sleep_request, .sleep_allow, .watchdog_restart, .sleep_counter_ctl);
	prm_cpu_model prm_cpu_model_i (.clock, .read_data, .address, .write_data, .write_strobe, .read_strobe);

	always #2 clock = ~clock;

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [3:0] e);
		logic [3:0] d;
		prm_cpu_model_i.read(a, d);
		chk({6'h00, d}, {6'h00, e});
	endtask : rd_chk
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		prm_cpu_model_i.write(a, d);
	endtask : wr
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// Whole sequence needs well under 500 cycles
	initial begin
		#20000;
		fails++;
		give_verdict();
	end

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		port_pin_in = 6'h00;
		irq_request = 8'h00;
		watchdog_value = 2'h0;
		serial_busy = 1'b0;
		counter_value = 10'h000;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		foreach (zero_regs[i]) rd_chk(zero_regs[i], 4'h0);
		rd_chk(8'h6a, 4'h8);
		foreach (rw_regs[i]) wr(rw_regs[i], ~rw_regs[i][3:0]);
		foreach (rw_regs[i]) rd_chk(rw_regs[i], ~rw_regs[i][3:0]);
		chk(serial_data, 8'h56);
		chk(port_drive_enable, 6'h0e);
		chk(edge_debounce_ctl, 4'hd);
		chk(wake_irq_ctl, 4'hc);
		chk(pulldown_off, 4'hb);
		chk(open_drain_sel[3:0], 4'ha);
		chk(freq_reset_ctl, 4'h9);
		chk(serial_ctl_one, 4'h8);
		chk(counter_ctl_one, 4'h4);
		chk({route_one, route_two}, 8'hed);
		chk(sleep_counter_ctl, 4'h4);
		port_pin_in <= 6'h2b;
		repeat (3) @(posedge clock);
		rd_chk(8'h50, 4'hb);
		wr(8'h50, 4'h6);
		wr(8'h60, 4'he);
		chk(port_out_value, 6'h26);
		chk({port_drive_enable[5], open_drain_sel[5]}, 2'h3);
		rd_chk(8'h60, 4'he);
		counter_value <= 10'h2a5;
		wr(8'h5d, 4'h1);
		wr(8'h5e, 4'h2);
		wr(8'h5f, 4'hc);
		wr(8'h5c, 4'hf);
		chk(counter_load, 1'b1);
		chk({width_select, reload_value}, {2'h3, 10'h021});
		chk(counter_ctl_two, 3'h7);
		rd_chk(8'h5c, 4'he);
		rd_chk(8'h5d, 4'h5);
		rd_chk(8'h5f, 4'he);
		serial_busy <= 1'b1;
		wr(8'h58, 4'h9);
		rd_chk(8'h58, 4'hd);
		chk(serial_ctl_two, 4'h9);
		wr(8'h65, 4'h0);
		irq_request <= 8'h01;
		repeat (4) @(posedge clock);
		rd_chk(8'h67, 4'h0);
		irq_request <= 8'h00;
		wr(8'h65, 4'hf);
		wr(8'h66, 4'hf);
		irq_request <= 8'h13;
		repeat (4) @(posedge clock);
		chk(irq_flags, 8'h13);
		rd_chk(8'h67, 4'h3);
		rd_chk(8'h67, 4'h0);
		wr(8'h68, 4'h0);
		chk(irq_flags, 8'h10);
		wr(8'h68, 4'h1);
		chk(irq_flags, 8'h00);
		// Fresh edge, then quiet requests, so the read clear acts on a set flag
		irq_request <= 8'h17;
		repeat (4) @(posedge clock);
		irq_request <= 8'h00;
		rd_chk(8'h67, 4'h4);
		wr(8'h69, 4'hf);
		chk(sleep_request, 1'b1);
		chk(system_ctl_one, 4'hb);
		rd_chk(8'h69, 4'hb);
		watchdog_value <= 2'h1;
		wr(8'h6a, 4'hc);
		chk(watchdog_restart, 1'b1);
		chk(sleep_allow, 1'b1);
		rd_chk(8'h6a, 4'hd);
		wr(8'h63, 4'hf);
		chk(port_out_value, 6'h26);
		rd_chk(8'h63, 4'h0);
		rd_chk(8'h64, 4'h0);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		chk(port_drive_enable, 6'h00);
		rd_chk(8'h65, 4'h0);
		rd_chk(8'h6a, 4'h9);
		give_verdict();
	end
endmodule : testbench
